/* File: shared/fcb_map.vh */
// constants for the command-behaviour configuration block: serial opcodes,
// register addresses, field positions and reset values.
// assumes a serial mode-0 host and a nonvolatile array that keeps the boot byte.
`ifndef FCB_MAP_VH
`define FCB_MAP_VH

`define FCB_OP_READ_ANY   8'h65
`define FCB_OP_WRITE_ANY  8'h71
`define FCB_OP_30H        8'h30
`define FCB_OP_BLK_ERASE  8'hD8
`define FCB_OP_BLK_ERASE4 8'hDC
`define FCB_OP_PARAM_ER   8'h20
`define FCB_OP_BULK_ER    8'h60
`define FCB_OP_BULK_ER2   8'hC7
`define FCB_OP_LEGACY_RST 8'hF0
`define FCB_OP_RST_ARM    8'h66
`define FCB_OP_RST_FIRE   8'h99

`define FCB_ADDR_BOOT     24'h00_0004
`define FCB_ADDR_LIVE     24'h80_0004

`define FCB_BIT_BLANK     5
`define FCB_BIT_WRAP      4
`define FCB_BIT_PARAM     3
`define FCB_BIT_RESUME    2
`define FCB_BIT_BLKSIZE   1
`define FCB_BIT_LEGACY    0
`define FCB_USED_MASK     8'h3F
`define FCB_RESET_VAL     8'h00

`define FCB_KIND_PARAM    2'h0
`define FCB_KIND_SECTOR   2'h1
`define FCB_KIND_BULK     2'h2

`endif

/* File: design/fcb_sync.v */
// three-stage input filter for signals from outside the clk domain.
// the output changes only once stages two and three agree.
`timescale 1ns/1ps
module fcb_sync
#(
   parameter W     = 3,
   parameter RSTV  = 0
)
(
   input  wire         clk,
   input  wire         rst,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   integer     i;

   // s1_q feeds s2_q only; filtering looks at s2/s3
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_q <= RSTV[W-1:0];
         s2_q <= RSTV[W-1:0];
         s3_q <= RSTV[W-1:0];
         dout <= RSTV[W-1:0];
      end
      else
      begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (i = 0; i < W; i = i + 1)
         begin
            if (s2_q[i] == s3_q[i])
               dout[i] <= s3_q[i];
         end
      end
   end
endmodule // fcb_sync

/* File: design/fcb_erase_seq.v */
// erase launcher with optional blank check ahead of the real erase.
// assumes the array answers scan requests and reports the last erase status.
`timescale 1ns/1ps
`include "fcb_map.vh"
module fcb_erase_seq
(
   input  wire        clk,
   input  wire        rst,
   input  wire        start,
   input  wire [1:0]  kind,
   input  wire [23:0] addr,
   input  wire        blank_en,
   input  wire        last_erase_ok,
   input  wire        scan_done,
   input  wire        scan_zero,
   output wire        busy,
   output reg         scan_req,
   output reg         erase_go,
   output reg         erase_skip,
   output reg  [1:0]  erase_kind,
   output reg  [23:0] erase_addr
);
   localparam ST_IDLE = 2'd0;
   localparam ST_EVAL = 2'd1;
   localparam ST_SCAN = 2'd2;

   reg [1:0] st_q;

   assign busy = (st_q != ST_IDLE);

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_q       <= ST_IDLE;
         scan_req   <= 1'b0;
         erase_go   <= 1'b0;
         erase_skip <= 1'b0;
         erase_kind <= 2'h0;
         erase_addr <= 24'h00_0000;
      end
      else
      begin
         erase_go   <= 1'b0;
         erase_skip <= 1'b0;
         case (st_q)
            ST_IDLE:
            begin
               if (start)
               begin
                  erase_kind <= kind;
                  erase_addr <= addr;
                  if (blank_en)
                     st_q <= ST_EVAL;
                  else
                     erase_go <= 1'b1;
               end
            end
            ST_EVAL:
            begin
               if (!last_erase_ok)
               begin
                  erase_go <= 1'b1;
                  st_q     <= ST_IDLE;
               end
               else
               begin
                  scan_req <= 1'b1;
                  st_q     <= ST_SCAN;
               end
            end
            ST_SCAN:
            begin
               // first zero wins over done so the erase is never lost
               if (scan_zero)
               begin
                  scan_req <= 1'b0;
                  erase_go <= 1'b1;
                  st_q     <= ST_IDLE;
               end
               else if (scan_done)
               begin
                  scan_req   <= 1'b0;
                  erase_skip <= 1'b1;
                  st_q       <= ST_IDLE;
               end
            end
            default:
               st_q <= ST_IDLE;
         endcase
      end
   end
endmodule // fcb_erase_seq

/* File: design/fcb_cfg_top.v */
// serial command front end holding the live behaviour byte and reading the boot byte.
// assumes mode-0 serial pins from the host and an external one-time array
// that stores the boot image and sets bits on a program pulse.
`timescale 1ns/1ps
`include "fcb_map.vh"
module fcb_cfg_top
(
   input  wire        clk,
   input  wire        rst,
   input  wire        sck,
   input  wire        cs_n,
   input  wire        si,
   input  wire        hw_reset_n,
   output wire        so_o,
   output wire        so_oe,
   input  wire [7:0]  nv_image,
   output reg         nv_prog,
   output reg  [7:0]  nv_prog_bits,
   input  wire        last_erase_ok,
   input  wire        scan_done,
   input  wire        scan_zero,
   output wire        scan_req,
   output wire        erase_go,
   output wire        erase_skip,
   output wire [1:0]  erase_kind,
   output wire [23:0] erase_addr,
   output reg         erase_block_256k,
   output wire        erase_busy,
   output reg         resume_pulse,
   output reg         clear_status_pulse,
   output reg         soft_reset_pulse,
   output reg         param_sectors_on,
   input  wire [8:0]  buf_addr_in,
   output reg  [8:0]  buf_addr_out,
   output wire [7:0]  behavior_cfg_live
);
   ////////////////////////////////////////////////////////////////////////
   // pin filtering and edge finding
   wire       sck_f;
   wire       cs_n_f;
   wire       si_f;
   wire       hwr_n_f;
   reg        sck_prev_q;
   reg        cs_prev_q;
   reg        hwr_prev_q;
   wire       sck_rise;
   wire       sck_fall;
   wire       cs_end;
   wire       hw_reset_ev;

   // reset value matches idle pins (reset high, deselected, sck low) so no false edge follows
   fcb_sync #(.W(4), .RSTV(4'hC)) u_sync
   (
      .clk  (clk),
      .rst  (rst),
      .din  ({hw_reset_n, cs_n, si, sck}),
      .dout ({hwr_n_f, cs_n_f, si_f, sck_f})
   );

   assign sck_rise    = sck_f & ~sck_prev_q & ~cs_n_f;
   assign sck_fall    = ~sck_f & sck_prev_q & ~cs_n_f;
   assign cs_end      = cs_n_f & ~cs_prev_q;
   assign hw_reset_ev = ~hwr_n_f & hwr_prev_q;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sck_prev_q <= 1'b0;
         cs_prev_q  <= 1'b1;
         hwr_prev_q <= 1'b1;
      end
      else
      begin
         sck_prev_q <= sck_f;
         cs_prev_q  <= cs_n_f;
         hwr_prev_q <= hwr_n_f;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // byte assembly
   reg  [2:0]  bit_cnt_q;
   reg  [2:0]  byte_cnt_q;
   reg  [6:0]  sh_q;
   reg  [7:0]  op_q;
   reg  [23:0] addr_q;
   reg  [7:0]  wdata_q;
   reg  [7:0]  out_sh_q;
   reg         rd_phase_q;
   reg         so_q;
   reg         rst_armed_q;
   reg  [7:0]  live_q;
   reg         load_q;
   wire [7:0]  byte_in;
   wire        byte_done;
   wire [7:0]  boot_view;

   assign byte_in   = {sh_q, si_f};
   assign byte_done = sck_rise & (bit_cnt_q == 3'd7);
   assign boot_view = nv_image & `FCB_USED_MASK;

   // register read decode; unmapped addresses read zero
   function [7:0] rd_mux;
      input [23:0] a;
      input [7:0]  bootv;
      input [7:0]  livev;
      begin
         if (a == `FCB_ADDR_BOOT)
            rd_mux = bootv;
         else if (a == `FCB_ADDR_LIVE)
            rd_mux = livev & `FCB_USED_MASK;
         else
            rd_mux = 8'h00;
      end
   endfunction

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         bit_cnt_q  <= 3'd0;
         byte_cnt_q <= 3'd0;
         sh_q       <= 7'h00;
         op_q       <= 8'h00;
         addr_q     <= 24'h00_0000;
         wdata_q    <= 8'h00;
         out_sh_q   <= 8'h00;
         rd_phase_q <= 1'b0;
         so_q       <= 1'b0;
      end
      else if (cs_n_f)
      begin
         bit_cnt_q  <= 3'd0;
         byte_cnt_q <= 3'd0;
         rd_phase_q <= 1'b0;
      end
      else
      begin
         if (sck_rise)
         begin
            sh_q      <= byte_in[6:0];
            bit_cnt_q <= bit_cnt_q + 3'd1;
         end
         if (byte_done)
         begin
            if (byte_cnt_q != 3'd7)
               byte_cnt_q <= byte_cnt_q + 3'd1;
            case (byte_cnt_q)
               3'd0: op_q <= byte_in;
               3'd1: addr_q[23:16] <= byte_in;
               3'd2: addr_q[15:8] <= byte_in;
               3'd3:
               begin
                  addr_q[7:0] <= byte_in;
                  if (op_q == `FCB_OP_READ_ANY)
                  begin
                     // the read repeats the same byte for as long as clocks continue
                     out_sh_q   <= rd_mux({addr_q[23:8], byte_in},
                                          boot_view, live_q);
                     rd_phase_q <= 1'b1;
                  end
               end
               3'd4: wdata_q <= byte_in;
               default: wdata_q <= wdata_q;
            endcase
         end
         if (sck_fall && rd_phase_q)
         begin
            so_q     <= out_sh_q[7];
            out_sh_q <= {out_sh_q[6:0], out_sh_q[7]};
         end
      end
   end

   assign so_o  = so_q;
   assign so_oe = rd_phase_q & ~cs_n_f;

   ////////////////////////////////////////////////////////////////////////
   // command execution at the end of a frame
   wire       is_erase_op;
   wire       erase_start;
   wire [1:0] erase_kind_d;
   wire       soft_reset_ev;
   wire       write_ok;

   assign write_ok    = cs_end & (op_q == `FCB_OP_WRITE_ANY) & (byte_cnt_q >= 3'd5);
   assign is_erase_op = (op_q == `FCB_OP_PARAM_ER) | (op_q == `FCB_OP_BLK_ERASE) |
                        (op_q == `FCB_OP_BLK_ERASE4);
   assign erase_start = cs_end & ~erase_busy &
                        ((is_erase_op & (byte_cnt_q == 3'd4)) |
                         (((op_q == `FCB_OP_BULK_ER) | (op_q == `FCB_OP_BULK_ER2)) &
                          (byte_cnt_q == 3'd1)));
   assign erase_kind_d = (op_q == `FCB_OP_PARAM_ER) ? `FCB_KIND_PARAM :
                         is_erase_op ? `FCB_KIND_SECTOR : `FCB_KIND_BULK;

   assign soft_reset_ev = cs_end & (byte_cnt_q == 3'd1) &
                          (((op_q == `FCB_OP_LEGACY_RST) &
                            live_q[`FCB_BIT_LEGACY]) |
                           ((op_q == `FCB_OP_RST_FIRE) & rst_armed_q));

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rst_armed_q        <= 1'b0;
         resume_pulse       <= 1'b0;
         clear_status_pulse <= 1'b0;
         soft_reset_pulse   <= 1'b0;
         nv_prog            <= 1'b0;
         nv_prog_bits       <= 8'h00;
         erase_block_256k   <= 1'b0;
      end
      else
      begin
         resume_pulse       <= 1'b0;
         clear_status_pulse <= 1'b0;
         soft_reset_pulse   <= soft_reset_ev;
         nv_prog            <= 1'b0;
         if (cs_end)
            rst_armed_q <= (op_q == `FCB_OP_RST_ARM) & (byte_cnt_q == 3'd1);
         if (cs_end && op_q == `FCB_OP_30H && byte_cnt_q == 3'd1)
         begin
            resume_pulse       <= live_q[`FCB_BIT_RESUME];
            clear_status_pulse <= ~live_q[`FCB_BIT_RESUME];
         end
         if (erase_start)
            erase_block_256k <= live_q[`FCB_BIT_BLKSIZE];
         // only 0 to 1 requests go out, so the array can never clear a bit
         if (write_ok && addr_q == `FCB_ADDR_BOOT)
         begin
            nv_prog      <= 1'b1;
            nv_prog_bits <= wdata_q & ~nv_image & `FCB_USED_MASK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // live byte; reload is taken one edge after any reset event
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         live_q <= `FCB_RESET_VAL;
         load_q <= 1'b1;
      end
      else
      begin
         load_q <= soft_reset_ev | hw_reset_ev;
         if (load_q)
            live_q <= boot_view;
         else
         begin
            if (write_ok && addr_q == `FCB_ADDR_LIVE)
               live_q <= wdata_q & `FCB_USED_MASK;
            // param bit tracks the boot copy; host writes to it have no effect
            live_q[`FCB_BIT_PARAM] <= nv_image[`FCB_BIT_PARAM];
         end
      end
   end

   assign behavior_cfg_live = live_q;

   ////////////////////////////////////////////////////////////////////////
   // effects of the live bits
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         param_sectors_on <= 1'b1;
         buf_addr_out     <= 9'h000;
      end
      else
      begin
         param_sectors_on <= ~live_q[`FCB_BIT_PARAM];
         buf_addr_out     <= live_q[`FCB_BIT_WRAP] ? buf_addr_in :
                             {1'b0, buf_addr_in[7:0]};
      end
   end

   fcb_erase_seq u_erase
   (
      .clk           (clk),
      .rst           (rst),
      .start         (erase_start),
      .kind          (erase_kind_d),
      .addr          (addr_q),
      .blank_en      (live_q[`FCB_BIT_BLANK]),
      .last_erase_ok (last_erase_ok),
      .scan_done     (scan_done),
      .scan_zero     (scan_zero),
      .busy          (erase_busy),
      .scan_req      (scan_req),
      .erase_go      (erase_go),
      .erase_skip    (erase_skip),
      .erase_kind    (erase_kind),
      .erase_addr    (erase_addr)
   );
endmodule // fcb_cfg_top

/* File: dv/fcb_cfg_checker.sv */
// concurrent checks on the behaviour byte block, seen from its ports.
// assumes a bind onto fcb_cfg_top with one clock domain.
`timescale 1ns/1ps
module fcb_cfg_checker
(
   input logic       clk,
   input logic       rst,
   input logic [7:0] nv_image,
   input logic       nv_prog,
   input logic [7:0] nv_prog_bits,
   input logic       scan_req,
   input logic       erase_go,
   input logic       erase_skip,
   input logic       erase_block_256k,
   input logic       resume_pulse,
   input logic       clear_status_pulse,
   input logic       soft_reset_pulse,
   input logic       param_sectors_on,
   input logic [8:0] buf_addr_in,
   input logic [8:0] buf_addr_out,
   input logic [7:0] behavior_cfg_live
);
////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_upper_zero: assert property (behavior_cfg_live[7:6] == 2'b00)
      else $error("reserved live bits set");
   a_boot_once: assert property (nv_prog |-> (nv_prog_bits & nv_image) == 8'h00)
      else $error("boot program touches a set bit");
   a_reload_live: assert property (soft_reset_pulse |->
      ##[1:3] behavior_cfg_live == (nv_image & 8'h3F))
      else $error("live byte not reloaded after soft reset");
   a_map_follow: assert property ($stable(behavior_cfg_live[3]) [*2] |->
      param_sectors_on == !behavior_cfg_live[3])
      else $error("sector map does not follow live byte");
   a_wrap_low: assert property (!behavior_cfg_live[4] && !$past(behavior_cfg_live[4])
      |-> !buf_addr_out[8])
      else $error("buffer address passed 255 with wrap");
   a_wrap_full: assert property (behavior_cfg_live[4] && $past(behavior_cfg_live[4])
      |-> buf_addr_out == $past(buf_addr_in))
      else $error("buffer address altered without wrap");
   a_resume_sel: assert property (resume_pulse |-> behavior_cfg_live[2])
      else $error("resume with select clear");
   a_clear_sel: assert property (clear_status_pulse |-> !behavior_cfg_live[2]
      && !resume_pulse)
      else $error("clear status with select set");
   a_scan_blank: assert property ($rose(scan_req) |-> behavior_cfg_live[5])
      else $error("scan without blank check");
   a_skip_scan: assert property (erase_skip |-> $past(scan_req) || $past(scan_req, 2))
      else $error("skip without scan");
   a_erase_size: assert property (erase_go |=>
      erase_block_256k == behavior_cfg_live[1])
      else $error("erase size differs from live bit");
endmodule // fcb_cfg_checker

/* File: dv/fcb_host_model.sv */
// host serial controller model: mode 0 frames, msb first.
// assumes the block clock; sck is high for HALF clk cycles and low for HALF+1.
`timescale 1ns/1ps
module fcb_host_model
#(
   parameter int HALF = 16
)
(
   input  logic clk,
   output logic sck = 1'b0,
   output logic cs_n = 1'b1,
   output logic si = 1'b0,
   input  logic so
);
////////////////////////////////////////////////////////////
   // sends nbit bits of d from bit 39 down; rd keeps the last 8 bits seen on so
   task automatic xfer(input logic [39:0] d, input int nbit, output logic [7:0] rd);
      int i;
      rd = 8'h00;
      @(posedge clk) cs_n <= 1'b0;
      for (i = 0; i < nbit; i++)
      begin
         @(posedge clk) si <= d[39 - i];
         repeat (HALF) @(posedge clk);
         rd = {rd[6:0], so};
         sck <= 1'b1;
         repeat (HALF) @(posedge clk);
         sck <= 1'b0;
      end
      repeat (HALF) @(posedge clk);
      cs_n <= 1'b1;
      // released data line flips so a stale bit is never mistaken for a held one
      si <= ~si;
      repeat (2 * HALF) @(posedge clk);
   endtask
endmodule // fcb_host_model

/* File: dv/flash_command_behavior_config_tb_top.sv */
// self-checking bench for the behaviour byte block.
// assumes fcb_map.vh on the include path; the one-time array is modelled here.
`timescale 1ns/1ps
`include "fcb_map.vh"
module flash_command_behavior_config_tb_top;
   logic clk = 0, rst = 1, hw_reset_n = 1, last_erase_ok = 0, scan_done = 0, scan_zero = 0;
   logic sck, cs_n, si, so_o, so_oe, nv_prog, scan_req, erase_go, erase_skip;
   logic erase_block_256k, erase_busy, resume_pulse, clear_status_pulse;
   logic soft_reset_pulse, param_sectors_on;
   logic [7:0] nv_img_q = 8'h00, nv_prog_bits, behavior_cfg_live, rd;
   logic [1:0] erase_kind;
   logic [23:0] erase_addr;
   logic [8:0] buf_addr_in = 9'h000, buf_addr_out;
   int n_errors = 0, n_compared = 0, cnt[6] = '{default: 0}, base[6];
////////////////////////////////////////////////////////////
   always #2.5 clk = ~clk;
   // one-time array: bits only ever OR in
   always @(posedge clk) if (nv_prog === 1'b1) nv_img_q <= nv_img_q | nv_prog_bits;
   always @(posedge clk)
   begin
      cnt[0] <= cnt[0] + (resume_pulse === 1'b1);
      cnt[1] <= cnt[1] + (clear_status_pulse === 1'b1);
      cnt[2] <= cnt[2] + (soft_reset_pulse === 1'b1);
      cnt[3] <= cnt[3] + (erase_go === 1'b1);
      cnt[4] <= cnt[4] + (erase_skip === 1'b1);
      cnt[5] <= cnt[5] + (so_oe === 1'b1);
   end
   fcb_host_model host (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so_o));
   fcb_cfg_top uut (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
      .hw_reset_n(hw_reset_n), .so_o(so_o), .so_oe(so_oe), .nv_image(nv_img_q),
      .nv_prog(nv_prog), .nv_prog_bits(nv_prog_bits), .last_erase_ok(last_erase_ok),
      .scan_done(scan_done), .scan_zero(scan_zero), .scan_req(scan_req),
      .erase_go(erase_go), .erase_skip(erase_skip), .erase_kind(erase_kind),
      .erase_addr(erase_addr), .erase_block_256k(erase_block_256k),
      .erase_busy(erase_busy), .resume_pulse(resume_pulse),
      .clear_status_pulse(clear_status_pulse), .soft_reset_pulse(soft_reset_pulse),
      .param_sectors_on(param_sectors_on), .buf_addr_in(buf_addr_in),
      .buf_addr_out(buf_addr_out), .behavior_cfg_live(behavior_cfg_live));
////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error %0t: value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int idx, input int exp);
      n_compared++;
      if (cnt[idx] - base[idx] != exp)
      begin
         n_errors++;
         $display("Error %0t: pulse %0d count %0d expected %0d", $time, idx,
            cnt[idx] - base[idx], exp);
      end
   endtask
   task automatic wr(input logic [23:0] a, input logic [7:0] d);
      base = cnt;
      host.xfer({`FCB_OP_WRITE_ANY, a, d}, 40, rd);
      chk_val(cnt[5] - base[5], 0);
   endtask
   task automatic rdr(input logic [23:0] a, input logic [7:0] exp);
      base = cnt;
      host.xfer({`FCB_OP_READ_ANY, a, 8'h00}, 40, rd);
      chk_val(rd, exp);
      chk_val(cnt[5] - base[5] > 200, 1'b1);
      chk_val(so_oe, 1'b0);
   endtask
   task automatic cmd(input logic [7:0] op, input int nbit);
      base = cnt;
      host.xfer({op, 24'h01_0000, 8'h00}, nbit, rd);
   endtask
   // blank scan answer from the array, zero found or blank
   task automatic scan_answer(input logic zero);
      int i;
      for (i = 0; i < 50 && scan_req !== 1'b1; i++) @(posedge clk);
      if (i == 50)
      begin
         n_errors++;
         $display("Error %0t: scan request timed out", $time);
         complete_run;
      end
      scan_zero <= zero;
      scan_done <= !zero;
      @(posedge clk);
      scan_zero <= 1'b0;
      scan_done <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
////////////////////////////////////////////////////////////
   task automatic t_live;
      chk_val(behavior_cfg_live, 8'h00);
      chk_val(param_sectors_on, 1'b1);
      rdr(`FCB_ADDR_BOOT, 8'h00);
      wr(`FCB_ADDR_LIVE, 8'hF7); // bit3 kept at boot value
      chk_val(behavior_cfg_live, 8'h37);
      rdr(`FCB_ADDR_LIVE, 8'h37);
      rdr(24'h00_0010, 8'h00);
      buf_addr_in <= 9'h1A5;
      repeat (3) @(posedge clk);
      chk_val(buf_addr_out, 9'h1A5);
      wr(`FCB_ADDR_LIVE, 8'h00);
      chk_val(buf_addr_out, 9'h0A5);
      $display("test live done");
   endtask
   task automatic t_erase;
      logic [7:0] ops[3] = '{8'hD8, 8'h20, 8'h60};
      int nb[3] = '{32, 32, 8};
      logic [1:0] kd[3] = '{`FCB_KIND_SECTOR, `FCB_KIND_PARAM, `FCB_KIND_BULK};
      cmd(8'hD8, 32);
      chk_cnt(3, 1);
      chk_val(erase_block_256k, 1'b0);
      chk_val(erase_addr, 24'h01_0000);
      wr(`FCB_ADDR_LIVE, 8'h22);
      cmd(8'hDC, 32);
      chk_cnt(3, 1);
      chk_val(erase_block_256k, 1'b1);
      last_erase_ok <= 1'b1;
      cmd(8'hD8, 32);
      chk_val(erase_busy, 1'b1);
      scan_answer(1'b1);
      chk_cnt(3, 1);
      for (int k = 0; k < 3; k++)
      begin
         cmd(ops[k], nb[k]);
         chk_val(erase_busy, 1'b1);
         scan_answer(1'b0);
         chk_val(erase_busy, 1'b0);
         chk_cnt(4, 1);
         chk_cnt(3, 0);
         chk_val(erase_kind, kd[k]);
      end
      $display("test erase done");
   endtask
   task automatic t_cmds;
      wr(`FCB_ADDR_LIVE, 8'h05);
      cmd(`FCB_OP_30H, 8);
      chk_cnt(0, 1);
      cmd(`FCB_OP_LEGACY_RST, 8);
      chk_cnt(2, 1);
      chk_val(behavior_cfg_live, 8'h00);
      cmd(`FCB_OP_30H, 8);
      chk_cnt(1, 1);
      cmd(`FCB_OP_LEGACY_RST, 8);
      chk_cnt(2, 0);
      cmd(`FCB_OP_RST_FIRE, 8);
      chk_cnt(2, 0);
      cmd(`FCB_OP_RST_ARM, 8);
      host.xfer({`FCB_OP_RST_FIRE, 32'h0}, 8, rd);
      chk_cnt(2, 1);
      $display("test commands done");
   endtask
   task automatic t_boot;
      wr(`FCB_ADDR_BOOT, 8'hCD);
      rdr(`FCB_ADDR_BOOT, 8'h0D);
      wr(`FCB_ADDR_BOOT, 8'h00);
      rdr(`FCB_ADDR_BOOT, 8'h0D);
      hw_reset_n <= 1'b0;
      repeat (8) @(posedge clk);
      hw_reset_n <= 1'b1;
      repeat (8) @(posedge clk);
      chk_val(behavior_cfg_live, 8'h0D);
      chk_val(param_sectors_on, 1'b0);
      $display("test boot done");
   endtask
////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      t_live;
      t_erase;
      t_cmds;
      t_boot;
      complete_run;
   end
   initial
   begin
      repeat (90000) @(posedge clk);
      n_errors++;
      $display("Error %0t: run timed out", $time);
      complete_run;
   end
endmodule // flash_command_behavior_config_tb_top
bind fcb_cfg_top fcb_cfg_checker chk (.clk(clk), .rst(rst), .nv_image(nv_image),
   .nv_prog(nv_prog), .nv_prog_bits(nv_prog_bits), .scan_req(scan_req),
   .erase_go(erase_go), .erase_skip(erase_skip), .erase_block_256k(erase_block_256k),
   .resume_pulse(resume_pulse), .clear_status_pulse(clear_status_pulse),
   .soft_reset_pulse(soft_reset_pulse), .param_sectors_on(param_sectors_on),
   .buf_addr_in(buf_addr_in), .buf_addr_out(buf_addr_out),
   .behavior_cfg_live(behavior_cfg_live));
